// ### core/dsa_pc.sv
`timescale 1ns/1ps
// program counter and program address former
module dsa_pc (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // sequencing
  input  wire logic        pc_adv_i,
  input  wire logic        pc_dec_i,
  input  wire logic        pc_load_i,
  input  wire logic [22:0] pc_load_val_i,
  // table operations
  input  wire logic        table_read_op_i,
  input  wire logic        table_write_op_i,
  input  wire logic [7:0]  table_page_select_i,
  input  wire logic [15:0] table_offset_i,
  // program address
  output logic      [22:0] pc_o,
  output logic      [23:0] prog_addr_o,
  output logic             prog_upper_o,
  output logic             prog_vec_o,
  output logic             prog_ivt_o,
  output logic             prog_aivt_o
);
  typedef struct packed {
    logic [22:0] pc;
  } dsa_pc_s;

  dsa_pc_s st;
  dsa_pc_s next_st;
  logic    tbl;

  always_comb begin
    next_st = st;
    if (pc_load_i) begin
      next_st.pc = {pc_load_val_i[22:1], 1'b0};
    end else if (pc_adv_i) begin
      next_st.pc = st.pc + dsa_pkg::PC_STEP;
    end else if (pc_dec_i) begin
      next_st.pc = st.pc - dsa_pkg::PC_STEP;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st.pc <= dsa_pkg::PC_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign tbl = table_read_op_i | table_write_op_i;
  // only table ops may set the top bit, from page bit 7
  always_comb begin
    if (tbl) begin
      prog_addr_o = {table_page_select_i, table_offset_i};
    end else begin
      prog_addr_o = {1'b0, st.pc};
    end
  end
  assign pc_o         = st.pc;
  assign prog_upper_o = prog_addr_o[dsa_pkg::PROG_MSB];
  assign prog_vec_o   = prog_addr_o < dsa_pkg::VEC_END;
  assign prog_ivt_o   = prog_addr_o >= dsa_pkg::IVT_START
                        && prog_addr_o < dsa_pkg::AIVT_START;
  assign prog_aivt_o  = prog_addr_o >= dsa_pkg::AIVT_START
                        && prog_addr_o < dsa_pkg::VEC_END;

  property p_pc_even;
    @(posedge clk_i) disable iff (!rst_b_i) st.pc[0] == 1'b0;
  endproperty
  a_pc_even: assert property (p_pc_even) else $error("pc odd");

  property p_pc_step;
    @(posedge clk_i) disable iff (!rst_b_i)
      (pc_adv_i && !pc_load_i) |=> st.pc == $past(st.pc) + 23'h000002;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step wrong");

  property p_user_low;
    @(posedge clk_i) disable iff (!rst_b_i) !tbl |-> !prog_upper_o;
  endproperty
  a_user_low: assert property (p_user_low) else $error("user reached upper");

  c_tbl_upper: cover property (@(posedge clk_i) disable iff (!rst_b_i) tbl && prog_upper_o);
endmodule

// ### core/dsa_pkg.sv
// What this block does
// - program addresses are 24 bits, from the 23-bit counter or table operations
// - user fetches stay below 0x800000; table ops reach upper space via page bit 7
// - each program location is a 24-bit pair: lower even word, upper odd word
// - program counter stays even and steps by two
// - reset starts at 0x000000; jump target sits at 0x000002
// - region below 0x000200 holds vectors; two tables at 0x04 and 0x100
// - read and write data addresses come from separate generators
// - data effective addresses are 16-bit byte addresses, 64 Kbytes
// - bit 15 clear selects data memory, set selects program window
// - up to 16 Kbytes implemented; reads beyond return zero
// - low byte at even address, high byte at odd address
// - post-increment adds one for bytes, two for words
// - byte reads fetch the word and return the selected byte low
// - shared word decode with separate byte write strobes
// - word access to odd address is misaligned and traps
// - misaligned read completes; misaligned write is suppressed; then trap
// - byte load into a working register keeps its high byte
// - sign-extend byte to word and zero-extend clear high byte supported
// - 0x0000 to 0x07FF decodes as special function region
// - unused special function addresses read as zero
// - direct instructions reach 0x0000 to 0x1FFF by 13-bit field
// - 16-bit direct field or pointer register reaches all data space
package dsa_pkg;
  localparam int          PADDR_W       = 24;
  localparam int          PC_W          = 23;
  localparam int          DADDR_W       = 16;
  localparam int          DATA_W        = 16;
  localparam int          NEAR_W        = 13;
  localparam int          PAGE_W        = 8;
  localparam int          PAGE_MSB      = 7;
  localparam int          PROG_MSB      = 23;
  localparam int          WIN_BIT       = 15;
  localparam logic [22:0] PC_RESET      = 23'h000000;
  localparam logic [22:0] PC_STEP       = 23'h000002;
  localparam logic [23:0] JUMP_TGT_ADDR = 24'h000002;
  localparam logic [23:0] VEC_END       = 24'h000200;
  localparam logic [23:0] IVT_START     = 24'h000004;
  localparam logic [23:0] AIVT_START    = 24'h000100;
  localparam logic [15:0] SFR_END       = 16'h07FF;
  localparam logic [15:0] NEAR_END      = 16'h1FFF;
  localparam logic [15:0] RAM_BYTES     = 16'h4000;
  localparam logic [15:0] STEP_BYTE     = 16'h0001;
  localparam logic [15:0] STEP_WORD     = 16'h0002;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [7:0]  ONES_BYTE     = 8'hFF;
  localparam logic [7:0]  UPPER_PAD     = 8'h00;
endpackage

// ### core/dsa_ram.sv
`timescale 1ns/1ps
// byte-laned data memory; shared word decode, registered read data
module dsa_ram #(
  parameter int WORDS = 8192,
  parameter int AW    = 13
) (
  // clock
  input  wire logic        clk_i,
  // write side
  input  wire logic [AW-1:0] wr_word_i,
  input  wire logic [1:0]    wr_lane_i,
  input  wire logic [15:0]   wr_data_i,
  // read side
  input  wire logic [AW-1:0] rd_word_i,
  output logic      [15:0]   rd_data_o
);
  logic [15:0] mem [WORDS];

  always_ff @(posedge clk_i) begin
    if (wr_lane_i[0]) begin
      mem[wr_word_i][7:0] <= wr_data_i[7:0];
    end
    if (wr_lane_i[1]) begin
      mem[wr_word_i][15:8] <= wr_data_i[15:8];
    end
    rd_data_o <= mem[rd_word_i];
  end
endmodule

// ### core/dsa_unit.sv
`timescale 1ns/1ps
// data space access unit: address generators, lane select, alignment, decode
module dsa_unit #(
  parameter int RAM_WORDS = 8192,
  parameter int RAM_AW    = 13
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // program sequencing
  input  wire logic        pc_adv_i,
  input  wire logic        pc_dec_i,
  input  wire logic        pc_load_i,
  input  wire logic [22:0] pc_load_val_i,
  input  wire logic        table_read_op_i,
  input  wire logic        table_write_op_i,
  input  wire logic [7:0]  table_page_select_i,
  input  wire logic [15:0] table_offset_i,
  // program memory
  input  wire logic [23:0] prog_word_i,
  output logic      [22:0] pc_o,
  output logic      [23:0] prog_addr_o,
  output logic             prog_upper_o,
  output logic             prog_vec_o,
  output logic             prog_ivt_o,
  output logic             prog_aivt_o,
  output logic      [15:0] prog_lo_o,
  output logic      [15:0] prog_hi_o,
  // read address generator
  input  wire logic        rd_en_i,
  input  wire logic        rd_byte_i,
  input  wire logic        rd_direct_i,
  input  wire logic        rd_near_i,
  input  wire logic [15:0] rd_dir_addr_i,
  input  wire logic [15:0] rd_src_pointer_reg_i,
  input  wire logic        rd_post_inc_i,
  output logic      [15:0] rd_ptr_next_o,
  // write address generator
  input  wire logic        wr_en_i,
  input  wire logic        wr_byte_i,
  input  wire logic        wr_direct_i,
  input  wire logic        wr_near_i,
  input  wire logic [15:0] wr_dir_addr_i,
  input  wire logic [15:0] wr_dst_pointer_reg_i,
  input  wire logic        wr_post_inc_i,
  input  wire logic [15:0] wr_data_i,
  output logic      [15:0] wr_ptr_next_o,
  // special function registers and program window
  input  wire logic        sfr_hit_i,
  input  wire logic [15:0] sfr_rdata_i,
  output logic             sfr_rd_o,
  output logic             sfr_wr_o,
  output logic      [1:0]  sfr_lane_o,
  output logic      [15:0] sfr_addr_o,
  output logic      [15:0] sfr_wdata_o,
  input  wire logic [15:0] win_rdata_i,
  output logic             win_rd_o,
  output logic      [14:0] win_addr_o,
  // read result
  output logic      [15:0] rd_data_o,
  output logic             rd_valid_o,
  // working register byte merge and extend
  input  wire logic [15:0] wreg_old_i,
  input  wire logic        sign_extend_op_i,
  input  wire logic        zero_extend_op_i,
  output logic      [15:0] wreg_new_o,
  // exception
  input  wire logic        instr_done_i,
  output logic             addr_err_o
);
  typedef enum logic [1:0] {DSA_RAM, DSA_SFR, DSA_WIN, DSA_NONE} dsa_tgt_e;

  typedef struct packed {
    dsa_tgt_e    rd_tgt;
    logic        rd_bsel;
    logic        rd_byte;
    logic        rd_valid;
    logic        rd_done;
    logic [15:0] sfr_q;
    logic [15:0] win_q;
    logic        err_pend;
    logic        err;
    logic [15:0] rd_data;
  } dsa_unit_s;

  dsa_unit_s   st;
  dsa_unit_s   next_st;
  logic [15:0] rd_ea;
  logic [15:0] wr_ea;
  logic        rd_mis;
  logic        wr_mis;
  dsa_tgt_e    rd_tgt;
  dsa_tgt_e    wr_tgt;
  logic [1:0]  wr_lane;
  logic [1:0]  ram_lane;
  logic [15:0] ram_q;
  logic [15:0] word_q;
  logic [15:0] wdata_lane;

  // effective address: near 13-bit field, 16-bit field, or pointer
  function automatic logic [15:0] dsa_ea(input logic dir, input logic near,
                                         input logic [15:0] fld,
                                         input logic [15:0] ptr);
    logic [15:0] r;
    r = ptr;
    if (dir) begin
      r = near ? {3'b000, fld[dsa_pkg::NEAR_W-1:0]} : fld;
    end
    return r;
  endfunction

  // target decode of one effective address
  function automatic dsa_tgt_e dsa_decode(input logic [15:0] ea);
    dsa_tgt_e t;
    t = DSA_NONE;
    if (ea[dsa_pkg::WIN_BIT]) begin
      t = DSA_WIN;
    end else if (ea <= dsa_pkg::SFR_END) begin
      t = DSA_SFR;
    end else if (ea < dsa_pkg::RAM_BYTES) begin
      t = DSA_RAM;
    end
    return t;
  endfunction

  // post-increment step by size
  function automatic logic [15:0] dsa_step(input logic [15:0] p, input logic inc,
                                           input logic is_byte);
    logic [15:0] r;
    r = p;
    if (inc) begin
      r = p + (is_byte ? dsa_pkg::STEP_BYTE : dsa_pkg::STEP_WORD);
    end
    return r;
  endfunction

  dsa_pc u_pc (
    .clk_i               (clk_i),
    .rst_b_i             (rst_b_i),
    .pc_adv_i            (pc_adv_i),
    .pc_dec_i            (pc_dec_i),
    .pc_load_i           (pc_load_i),
    .pc_load_val_i       (pc_load_val_i),
    .table_read_op_i     (table_read_op_i),
    .table_write_op_i    (table_write_op_i),
    .table_page_select_i (table_page_select_i),
    .table_offset_i      (table_offset_i),
    .pc_o                (pc_o),
    .prog_addr_o         (prog_addr_o),
    .prog_upper_o        (prog_upper_o),
    .prog_vec_o          (prog_vec_o),
    .prog_ivt_o          (prog_ivt_o),
    .prog_aivt_o         (prog_aivt_o)
  );

  // lower word at even address, upper byte of upper word unimplemented
  assign prog_lo_o = prog_word_i[15:0];
  assign prog_hi_o = {dsa_pkg::UPPER_PAD, prog_word_i[23:16]};

  // independent read and write generators
  assign rd_ea         = dsa_ea(rd_direct_i, rd_near_i, rd_dir_addr_i, rd_src_pointer_reg_i);
  assign wr_ea         = dsa_ea(wr_direct_i, wr_near_i, wr_dir_addr_i, wr_dst_pointer_reg_i);
  assign rd_ptr_next_o = dsa_step(rd_src_pointer_reg_i, rd_post_inc_i, rd_byte_i);
  assign wr_ptr_next_o = dsa_step(wr_dst_pointer_reg_i, wr_post_inc_i, wr_byte_i);
  assign rd_tgt        = dsa_decode(rd_ea);
  assign wr_tgt        = dsa_decode(wr_ea);

  assign rd_mis = rd_en_i && !rd_byte_i && rd_ea[0];
  assign wr_mis = wr_en_i && !wr_byte_i && wr_ea[0];

  // byte lanes: even address low byte, odd address high byte
  always_comb begin
    if (wr_byte_i) begin
      wr_lane    = wr_ea[0] ? 2'b10 : 2'b01;
      wdata_lane = {wr_data_i[7:0], wr_data_i[7:0]};
    end else begin
      wr_lane    = 2'b11;
      wdata_lane = wr_data_i;
    end
  end
  // misaligned write is suppressed
  assign ram_lane    = (wr_en_i && !wr_mis && wr_tgt == DSA_RAM) ? wr_lane : 2'b00;
  assign sfr_wr_o    = wr_en_i && !wr_mis && wr_tgt == DSA_SFR;
  assign sfr_lane_o  = wr_lane;
  assign sfr_wdata_o = wdata_lane;
  assign sfr_rd_o    = rd_en_i && rd_tgt == DSA_SFR;
  assign sfr_addr_o  = sfr_wr_o ? {wr_ea[15:1], 1'b0} : {rd_ea[15:1], 1'b0};
  assign win_rd_o    = rd_en_i && rd_tgt == DSA_WIN;
  assign win_addr_o  = rd_ea[14:0];

  dsa_ram #(
    .WORDS (RAM_WORDS),
    .AW    (RAM_AW)
  ) u_ram (
    .clk_i     (clk_i),
    .wr_word_i (wr_ea[RAM_AW:1]),
    .wr_lane_i (ram_lane),
    .wr_data_i (wdata_lane),
    .rd_word_i (rd_ea[RAM_AW:1]),
    .rd_data_o (ram_q)
  );

  // word fetched one cycle later; unused or unimplemented reads give zero
  always_comb begin
    unique case (st.rd_tgt)
      DSA_RAM:  word_q = ram_q;
      DSA_SFR:  word_q = st.sfr_q;
      DSA_WIN:  word_q = st.win_q;
      DSA_NONE: word_q = {dsa_pkg::ZERO_BYTE, dsa_pkg::ZERO_BYTE};
    endcase
  end

  always_comb begin
    next_st          = st;
    next_st.rd_valid = rd_en_i;
    next_st.rd_tgt   = rd_tgt;
    next_st.rd_bsel  = rd_ea[0];
    next_st.rd_done  = st.rd_valid;
    next_st.rd_byte  = rd_byte_i;
    next_st.sfr_q    = sfr_hit_i ? sfr_rdata_i : 16'h0000;
    next_st.win_q    = win_rdata_i;
    if (st.rd_valid) begin
      if (st.rd_byte) begin
        next_st.rd_data = {dsa_pkg::ZERO_BYTE, st.rd_bsel ? word_q[15:8] : word_q[7:0]};
      end else begin
        next_st.rd_data = word_q;
      end
    end
    // hold the fault until the instruction completes, then one pulse
    next_st.err = 1'b0;
    if (instr_done_i && (st.err_pend || rd_mis || wr_mis)) begin
      next_st.err      = 1'b1;
      next_st.err_pend = 1'b0;
    end else if (rd_mis || wr_mis) begin
      next_st.err_pend = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '{rd_tgt: DSA_NONE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign rd_data_o  = st.rd_data;
  assign addr_err_o = st.err;

  // byte load keeps high byte; extend operations
  always_comb begin
    wreg_new_o = {wreg_old_i[15:8], st.rd_data[7:0]};
    if (sign_extend_op_i) begin
      wreg_new_o = {st.rd_data[7] ? dsa_pkg::ONES_BYTE : dsa_pkg::ZERO_BYTE,
                    st.rd_data[7:0]};
    end else if (zero_extend_op_i) begin
      wreg_new_o = {dsa_pkg::ZERO_BYTE, wreg_old_i[7:0]};
    end
  end
  // read data stands from the second edge after the request
  assign rd_valid_o = st.rd_done;

  property p_wr_suppress;
    @(posedge clk_i) disable iff (!rst_b_i) wr_mis |-> ram_lane == 2'b00 && !sfr_wr_o;
  endproperty
  a_wr_suppress: assert property (p_wr_suppress) else $error("misaligned write went out");

  property p_err_pulse;
    @(posedge clk_i) disable iff (!rst_b_i) addr_err_o |=> !addr_err_o;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error not single cycle");

  property p_err_cause;
    @(posedge clk_i) disable iff (!rst_b_i)
      (instr_done_i && (rd_mis || wr_mis)) |=> addr_err_o;
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("trap missing");

  property p_zero_out;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_en_i && rd_tgt == DSA_NONE) |=> ##1 rd_data_o == 16'h0000;
  endproperty
  a_zero_out: assert property (p_zero_out) else $error("unimplemented read nonzero");

  property p_byte_hi;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rd_en_i && rd_byte_i) |=> ##1 rd_data_o[15:8] == 8'h00;
  endproperty
  a_byte_hi: assert property (p_byte_hi) else $error("byte read high not zero");

  property p_step;
    @(posedge clk_i) disable iff (!rst_b_i)
      rd_post_inc_i |-> rd_ptr_next_o == rd_src_pointer_reg_i + (rd_byte_i ? 16'h0001 : 16'h0002);
  endproperty
  a_step: assert property (p_step) else $error("post increment wrong");

  property p_lane;
    @(posedge clk_i) disable iff (!rst_b_i)
      (wr_en_i && wr_byte_i && !wr_ea[0] && wr_tgt == DSA_RAM) |-> ram_lane == 2'b01;
  endproperty
  a_lane: assert property (p_lane) else $error("even byte lane wrong");

  property p_sfr_dec;
    @(posedge clk_i) disable iff (!rst_b_i) (rd_ea < 16'h0800) |-> rd_tgt == DSA_SFR;
  endproperty
  a_sfr_dec: assert property (p_sfr_dec) else $error("sfr decode wrong");

  property p_win;
    @(posedge clk_i) disable iff (!rst_b_i) (rd_en_i && rd_ea[15]) |-> win_rd_o;
  endproperty
  a_win: assert property (p_win) else $error("window not selected");

  c_err: cover property (@(posedge clk_i) disable iff (!rst_b_i) addr_err_o);
  c_byte_odd: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_en_i && rd_byte_i && rd_ea[0]);
  c_ram_wr: cover property (@(posedge clk_i) disable iff (!rst_b_i) ram_lane == 2'b11);
endmodule

// ### testbench/dsa_far.sv
`timescale 1ns/1ps
// far side: program memory, special function registers and program window
module dsa_far (
  // clock
  input  wire logic        clk_i,
  // program memory
  input  wire logic [23:0] prog_addr_i,
  output logic      [23:0] prog_word_o,
  // special function registers
  input  wire logic        sfr_rd_i,
  input  wire logic [15:0] sfr_addr_i,
  output logic             sfr_hit_o,
  output logic      [15:0] sfr_rdata_o,
  // program window
  input  wire logic        win_rd_i,
  input  wire logic [14:0] win_addr_i,
  output logic      [15:0] win_rdata_o
);
  logic tog = 1'b0;
  // unselected buses toggle so stale data cannot pass for an answer
  always @(posedge clk_i) tog <= ~tog;
  assign prog_word_o = {prog_addr_i[7:0], prog_addr_i[15:0] ^ 16'h5A3C};
  // only the lower part of the region is populated
  assign sfr_hit_o   = sfr_addr_i < 16'h0400;
  assign sfr_rdata_o = sfr_rd_i ? ({sfr_addr_i[15:1], 1'b0} ^ 16'hC3C3) : {16{tog}};
  assign win_rdata_o = win_rd_i ? ({1'b0, win_addr_i[14:1], 1'b0} ^ 16'h1234) : {16{tog}};
endmodule

// ### testbench/dsa_unit_tb.sv
`timescale 1ns/1ps
module dsa_unit_tb;
  logic        clk_i = 1'b0;
  logic        rst_b_i, pc_adv_i, pc_dec_i, pc_load_i, table_read_op_i, table_write_op_i;
  logic        rd_en_i, rd_byte_i, rd_direct_i, rd_near_i, rd_post_inc_i;
  logic        wr_en_i, wr_byte_i, wr_direct_i, wr_near_i, wr_post_inc_i, sfr_hit_i;
  logic        sign_extend_op_i, zero_extend_op_i, instr_done_i, chk_rd, d1, d2;
  logic [22:0] pc_load_val_i, pc_o;
  logic [7:0]  table_page_select_i;
  logic [23:0] prog_word_i, prog_addr_o, ta;
  logic [15:0] table_offset_i, rd_dir_addr_i, rd_src_pointer_reg_i, wr_dir_addr_i;
  logic [15:0] wr_dst_pointer_reg_i, wr_data_i, sfr_rdata_i, win_rdata_i, wreg_old_i;
  logic [15:0] prog_lo_o, prog_hi_o, rd_ptr_next_o, wr_ptr_next_o, sfr_addr_o, sfr_wdata_o;
  logic [15:0] rd_data_o, wreg_new_o;
  logic        prog_upper_o, prog_vec_o, prog_ivt_o, prog_aivt_o, sfr_rd_o, sfr_wr_o;
  logic        win_rd_o, rd_valid_o, addr_err_o;
  logic [1:0]  sfr_lane_o;
  logic [14:0] win_addr_o;
  logic [15:0] mem [0:8191];
  logic [15:0] exp_q [$];
  int          n_fail = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          seed_v;

  always #25 clk_i = ~clk_i;

  dsa_unit i_dut (.clk_i, .rst_b_i, .pc_adv_i, .pc_dec_i, .pc_load_i, .pc_load_val_i,
    .table_read_op_i, .table_write_op_i, .table_page_select_i, .table_offset_i, .prog_word_i,
    .pc_o, .prog_addr_o, .prog_upper_o, .prog_vec_o, .prog_ivt_o, .prog_aivt_o, .prog_lo_o,
    .prog_hi_o, .rd_en_i, .rd_byte_i, .rd_direct_i, .rd_near_i, .rd_dir_addr_i,
    .rd_src_pointer_reg_i, .rd_post_inc_i, .rd_ptr_next_o, .wr_en_i, .wr_byte_i, .wr_direct_i,
    .wr_near_i, .wr_dir_addr_i, .wr_dst_pointer_reg_i, .wr_post_inc_i, .wr_data_i,
    .wr_ptr_next_o, .sfr_hit_i, .sfr_rdata_i, .sfr_rd_o, .sfr_wr_o, .sfr_lane_o, .sfr_addr_o,
    .sfr_wdata_o, .win_rdata_i, .win_rd_o, .win_addr_o, .rd_data_o, .rd_valid_o, .wreg_old_i,
    .sign_extend_op_i, .zero_extend_op_i, .wreg_new_o, .instr_done_i, .addr_err_o);

  dsa_far i_far (.clk_i, .prog_addr_i(prog_addr_o), .prog_word_o(prog_word_i),
    .sfr_rd_i(sfr_rd_o), .sfr_addr_i(sfr_addr_o), .sfr_hit_o(sfr_hit_i),
    .sfr_rdata_o(sfr_rdata_i), .win_rd_i(win_rd_o), .win_addr_i(win_addr_o),
    .win_rdata_o(win_rdata_i));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_v(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_f(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic step();
    @(posedge clk_i);
    #5;
  endtask

  function automatic logic [15:0] exp_rd(input logic [15:0] ea, input logic byt);
    logic [15:0] w;
    if (ea[15]) w = {1'b0, ea[14:1], 1'b0} ^ 16'h1234;
    else if (ea <= 16'h07FF) w = (ea < 16'h0400) ? ({ea[15:1], 1'b0} ^ 16'hC3C3) : 16'h0000;
    else if (ea < 16'h4000) w = mem[ea[13:1]];
    else w = 16'h0000;
    return byt ? {8'h00, ea[0] ? w[15:8] : w[7:0]} : w;
  endfunction

  // mode 0 pointer, 1 full direct field, 2 near field with junk above bit 12
  task automatic rd(input logic [15:0] ea, input logic byt, input int mode, input logic chk);
    logic [15:0] fld;
    fld = (mode == 2) ? (ea | 16'hE000) : ea;
    rd_en_i = 1'b1;
    rd_byte_i = byt;
    rd_direct_i = (mode != 0);
    rd_near_i = (mode == 2);
    rd_dir_addr_i = (mode != 0) ? fld : ~fld;
    rd_src_pointer_reg_i = (mode == 0) ? ea : ~ea;
    chk_rd = chk;
    if (chk) exp_q.push_back(exp_rd(ea, byt));
    #1;
    chk_f(win_rd_o, ea[15]);
    chk_f(sfr_rd_o, ea <= 16'h07FF);
    step();
  endtask

  task automatic wset(input logic [15:0] ea, input logic byt, input logic [15:0] d);
    wr_en_i = 1'b1;
    wr_byte_i = byt;
    wr_direct_i = byt;
    wr_near_i = byt & ea[0];
    wr_dir_addr_i = byt ? (ea | (ea[0] ? 16'hE000 : 16'h0000)) : ~ea;
    wr_dst_pointer_reg_i = byt ? ~ea : ea;
    wr_data_i = d;
    if (ea >= 16'h0800 && ea < 16'h4000 && (byt || !ea[0])) begin
      if (byt && ea[0]) mem[ea[13:1]][15:8] = d[7:0];
      else if (byt) mem[ea[13:1]][7:0] = d[7:0];
      else mem[ea[13:1]] = d;
    end
  endtask

  task automatic idle();
    rd_en_i = 1'b0;
    wr_en_i = 1'b0;
    chk_rd = 1'b0;
  endtask

  // read data shows in the second cycle after the taking edge
  always @(posedge clk_i) begin
    d1 <= chk_rd;
    d2 <= d1;
  end
  always @(negedge clk_i) begin
    if (rd_valid_o === 1'b1) chk_v(24'(rd_data_o), 24'(exp_q.pop_front()));
    if (d2 === 1'b1 || rd_valid_o !== 1'b0) chk_f(rd_valid_o, d2);
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    {rst_b_i, pc_adv_i, pc_dec_i, pc_load_i, table_read_op_i, table_write_op_i, rd_en_i,
     rd_byte_i, rd_direct_i, rd_near_i, rd_post_inc_i, wr_en_i, wr_byte_i, wr_direct_i,
     wr_near_i, wr_post_inc_i, sign_extend_op_i, zero_extend_op_i, instr_done_i, chk_rd,
     pc_load_val_i, table_page_select_i, table_offset_i, rd_dir_addr_i, rd_src_pointer_reg_i,
     wr_dir_addr_i, wr_dst_pointer_reg_i, wr_data_i, wreg_old_i} = '0;
    {d1, d2} = 2'b00;
    seed_v = $urandom(32'h0a2eaaa5);
    repeat (5) @(posedge clk_i);
    chk_v(24'(pc_o), 24'h000000);
    chk_f(addr_err_o, 1'b0);
    chk_v(24'(rd_data_o), 24'h000000);
    #5;
    rst_b_i = 1'b1;
    chk_v(prog_addr_o, 24'h000000);
    pc_adv_i = 1'b1;
    repeat (3) step();
    pc_adv_i = 1'b0;
    chk_v(24'(pc_o), 24'h000006);
    pc_dec_i = 1'b1;
    step();
    pc_dec_i = 1'b0;
    chk_v(24'(pc_o), 24'h000004);
    pc_load_val_i = 23'h012345;
    pc_load_i = 1'b1;
    step();
    pc_load_i = 1'b0;
    chk_v(prog_addr_o, 24'h012344);
    chk_f(prog_upper_o, 1'b0);
    for (int i = 0; i < 8; i++) begin
      ta = (i == 7) ? 24'hF80010 : (i == 6) ? 24'h000200 : 24'(i * 16'h0055 * 4);
      table_read_op_i = !i[0];
      table_write_op_i = i[0];
      {table_page_select_i, table_offset_i} = ta;
      #1;
      chk_v(prog_addr_o, ta);
      chk_f(prog_upper_o, ta[23]);
      chk_f(prog_vec_o, ta < 24'h000200);
      chk_f(prog_ivt_o, ta >= 24'h000004 && ta <= 24'h0000FF);
      chk_f(prog_aivt_o, ta >= 24'h000100 && ta <= 24'h0001FF);
      chk_v(24'(prog_lo_o), 24'(ta[15:0] ^ 16'h5A3C));
      chk_v(24'(prog_hi_o), 24'(ta[7:0]));
      step();
    end
    {table_read_op_i, table_write_op_i} = 2'b00;
    for (int i = 0; i < 16; i++) begin
      wset(16'h0900 + 16'(2 * i), 1'b0, 16'($urandom));
      step();
    end
    wset(16'h2008, 1'b0, 16'h6E1D);
    step();
    wset(16'h0921, 1'b1, 16'h119C);
    step();
    wset(16'h0922, 1'b1, 16'h2277);
    step();
    idle();
    step();
    for (int i = 0; i < 16; i++) rd(16'h0900 + 16'(2 * i), 1'b0, i % 3, 1'b1);
    for (int i = 0; i < 6; i++) rd(16'h091E + 16'(i), 1'b1, i % 3, 1'b1);
    for (int i = 0; i < 8; i++) rd(16'h0012 + 16'(i * 16'h1FF7), i[0], i % 2, 1'b1);
    idle();
    wset(16'h0051, 1'b1, 16'h00AB);
    #1;
    chk_f(sfr_wr_o, 1'b1);
    chk_v(24'(sfr_lane_o), 24'h000002);
    chk_v(24'(sfr_addr_o), 24'h000050);
    chk_v(24'(sfr_wdata_o), 24'h00ABAB);
    step();
    wset(16'h0054, 1'b0, 16'h1234);
    #1;
    chk_v(24'(sfr_lane_o), 24'h000003);
    chk_v(24'(sfr_wdata_o), 24'h001234);
    step();
    wset(16'h0053, 1'b0, 16'h5678);
    #1;
    chk_f(sfr_wr_o, 1'b0);
    step();
    wset(16'h0903, 1'b0, 16'hFFFF);
    instr_done_i = 1'b1;
    step();
    idle();
    instr_done_i = 1'b0;
    chk_f(addr_err_o, 1'b1);
    step();
    chk_f(addr_err_o, 1'b0);
    rd(16'h0902, 1'b0, 0, 1'b1);
    rd(16'h0904, 1'b0, 0, 1'b1);
    rd(16'h0905, 1'b0, 0, 1'b1);
    idle();
    step();
    step();
    chk_f(addr_err_o, 1'b0);
    instr_done_i = 1'b1;
    step();
    instr_done_i = 1'b0;
    chk_f(addr_err_o, 1'b1);
    step();
    chk_f(addr_err_o, 1'b0);
    rd(16'h0921, 1'b1, 0, 1'b1);
    idle();
    step();
    wreg_old_i = 16'h5A5A;
    for (int m = 0; m < 3; m++) begin
      sign_extend_op_i = (m == 1);
      zero_extend_op_i = (m == 2);
      #1;
      chk_v(24'(wreg_new_o), m == 0 ? 24'h005A9C : m == 1 ? 24'h00FF9C : 24'h00005A);
      step();
    end
    for (int i = 0; i < 2; i++) begin
      rd_byte_i = i[0];
      wr_byte_i = i[0];
      rd_direct_i = 1'b0;
      wr_direct_i = 1'b0;
      rd_post_inc_i = 1'b1;
      wr_post_inc_i = 1'b1;
      rd_src_pointer_reg_i = 16'h0A00;
      wr_dst_pointer_reg_i = 16'h3FFE;
      #1;
      chk_v(24'(rd_ptr_next_o), i[0] ? 24'h000A01 : 24'h000A02);
      chk_v(24'(wr_ptr_next_o), i[0] ? 24'h003FFF : 24'h004000);
      step();
    end
    repeat (3) step();
    test_done();
  end
endmodule
